/* common/cpu_flags_pkg.sv */
/*
  shared constants, types and carriers for the instruction pointer and
  status/control flags block.
  assumes a single core clock and an apb register port with 32-bit data.
*/
package cpu_flags_pkg;

  // register byte offsets on the apb port
  localparam logic [11:0] OFS_FLAGS = 12'h000;
  localparam logic [11:0] OFS_IP = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00c;

  // flag bit positions
  localparam int CF_BIT = 0;
  localparam int PF_BIT = 2;
  localparam int AF_BIT = 4;
  localparam int ZF_BIT = 6;
  localparam int SF_BIT = 7;
  localparam int TF_BIT = 8;
  localparam int IF_BIT = 9;
  localparam int DF_BIT = 10;
  localparam int OF_BIT = 11;
  localparam int IO_PRIVILEGE_LEVEL_LO = 12;
  localparam int NT_BIT = 14;
  localparam int RF_BIT = 16;
  localparam int VM_BIT = 17;
  localparam int AC_BIT = 18;
  localparam int ID_BIT = 21;

  // control register field positions
  localparam int CTRL_PE = 0;
  localparam int CTRL_AM = 1;
  localparam int CTRL_FQE = 2;
  localparam int CTRL_CPL_LO = 4;

  // values after reset and write masks
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
  localparam logic [31:0] FLAGS_DEFINED = 32'h0027_7fd5;
  localparam logic [31:0] FLAGS_ONES = 32'h0000_0002;
  localparam logic [31:0] POP_MASK = 32'h0005_7dd5;
  localparam logic [31:0] LEGACY_MASK = 32'h0000_ffff;
  localparam logic [31:0] IP_RESET = 32'h0000_0000;
  localparam logic [1:0] CPL_RESET = 2'h0;

  typedef enum logic [1:0] {
    W8 = 2'b00,
    W16 = 2'b01,
    W32 = 2'b11
  } width_e;

  typedef enum logic [1:0] {
    LD_POP = 2'b00,
    LD_IRET = 2'b01,
    LD_TASK = 2'b11
  } load_e;

  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_ACC = 1'b1
  } apb_ph_e;

  typedef struct packed {
    logic valid;
    logic sub;
    width_e width;
    logic [31:0] a;
    logic [31:0] b;
  } alu_req_s;

  typedef struct packed {
    logic valid;
    logic [3:0] len;
    logic redirect;
    logic [31:0] target;
  } retire_s;

  typedef struct packed {
    logic valid;
    load_e kind;
    logic wide;
    logic [31:0] value;
  } flag_load_s;

  typedef struct packed {
    logic io_req;
    logic priv_op;
    logic mem_req;
    logic misaligned;
    logic debug_hit;
  } checks_s;

  typedef struct packed {
    logic step_trap;
    logic irq_ack;
    logic io_gp;
    logic vm_gp;
    logic align_fault;
    logic debug_fault;
    logic debug_suppress;
    logic task_return;
  } events_s;

  typedef struct packed {
    logic [31:0] result;
    logic cf;
    logic pf;
    logic af;
    logic zf;
    logic sf;
    logic of;
  } alu_flags_s;

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_s;

endpackage : cpu_flags_pkg

/* src/pin_sync.sv */
/*
  two flip-flop synchroniser for one asynchronous pin.
  assumes the pin may change at any time relative to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and synchronised level
  input wire logic pin,
  output logic level
);

  cpu_flags_pkg::sync_state_s st_q;
  cpu_flags_pkg::sync_state_s st_d;

  // meta feeds only the second stage
  always_comb begin
    st_d.meta = pin;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.stable;

endmodule : pin_sync

`default_nettype wire

/* src/flag_calc.sv */
/*
  arithmetic result flags for an 8, 16 or 32 bit add or subtract.
  assumes operands come from the same clock; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module flag_calc (
  // operation
  input wire cpu_flags_pkg::alu_req_s req,
  // result and flags
  output cpu_flags_pkg::alu_flags_s out
);

  logic [31:0] b_eff;
  logic [32:0] sum;
  logic [32:0] cvec;
  logic [31:0] mask;
  logic [5:0] msb;

  always_comb begin
    b_eff = req.sub ? ~req.b : req.b;
    sum = {1'b0, req.a} + {1'b0, b_eff} + {32'h0000_0000, req.sub};
    // carry into each bit, top entry is carry out of bit 31
    cvec = {sum[32], req.a ^ b_eff ^ sum[31:0]};
    case (req.width)
      cpu_flags_pkg::W8: begin
        mask = 32'h0000_00ff;
        msb = 6'd7;
      end
      cpu_flags_pkg::W16: begin
        mask = 32'h0000_ffff;
        msb = 6'd15;
      end
      default: begin
        mask = 32'hffff_ffff;
        msb = 6'd31;
      end
    endcase
    out.result = sum[31:0] & mask;
    // a subtract borrows when no carry comes out
    out.cf = cvec[msb + 6'd1] ^ req.sub;
    out.pf = ~^sum[7:0];
    out.af = cvec[4] ^ req.sub;
    out.zf = (out.result == 32'h0000_0000);
    out.sf = sum[msb];
    out.of = cvec[msb + 6'd1] ^ cvec[msb];
  end

endmodule : flag_calc

`default_nettype wire

/* src/instr_pointer_and_flags_reg.sv */
/*
  instruction pointer and 32-bit status/control flags word, with an apb
  register port, flag derivation from arithmetic results and the control
  flag checks made on the core's check strobes, with trap and interrupt taken at instruction boundaries.
  assumes the execution core gives retire, load and check strobes on pclk,
  and that maskable_irq_pin is asynchronous.
*/
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module instr_pointer_and_flags_reg (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // execution core requests
  input wire cpu_flags_pkg::alu_req_s alu_req,
  input wire cpu_flags_pkg::retire_s retire,
  input wire cpu_flags_pkg::flag_load_s flag_load,
  input wire cpu_flags_pkg::checks_s checks,
  input wire logic maskable_irq_pin,
  // state and events back to the core
  output logic [31:0] next_instr_pointer,
  output logic [31:0] status_control_word,
  output logic [15:0] legacy_flags,
  output logic [31:0] alu_result,
  output logic dir_down,
  output logic seg_real_style,
  output cpu_flags_pkg::events_s events
);

  typedef struct packed {
    logic [31:0] ip;
    logic [31:0] flags;
    logic pe;
    logic am;
    logic fqe;
    logic [1:0] current_priv_level;
    logic step_armed;
    cpu_flags_pkg::apb_ph_e ph;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] result;
    logic dir_down;
    logic seg_real;
    cpu_flags_pkg::events_s ev;
  } core_state_s;

  core_state_s st_q;
  core_state_s st_d;
  cpu_flags_pkg::alu_flags_s calc;
  logic irq_level;
  logic [2:0] sel_setup;
  logic [2:0] sel_acc;
  logic [1:0] io_privilege_level_q;
  logic [31:0] load_mask;

  // returns {mapped, index}
  function automatic logic [2:0] decode_addr(input logic [11:0] addr);
    if (addr == cpu_flags_pkg::OFS_FLAGS) begin
      return 3'b100;
    end else if (addr == cpu_flags_pkg::OFS_IP) begin
      return 3'b101;
    end else if (addr == cpu_flags_pkg::OFS_CTRL) begin
      return 3'b110;
    end else if (addr == cpu_flags_pkg::OFS_STAT) begin
      return 3'b111;
    end else begin
      return 3'b000;
    end
  endfunction : decode_addr

  // masked update that also pins the reserved bits
  function automatic logic [31:0] merge_flags(input logic [31:0] old,
                                              input logic [31:0] nv,
                                              input logic [31:0] mask);
    logic [31:0] m;
    m = mask & cpu_flags_pkg::FLAGS_DEFINED;
    return (old & ~m) | (nv & m) | cpu_flags_pkg::FLAGS_ONES;
  endfunction : merge_flags

  flag_calc u_calc (
    .req(alu_req),
    .out(calc)
  );

  pin_sync u_irq_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(maskable_irq_pin),
    .level(irq_level)
  );

  assign io_privilege_level_q = st_q.flags[cpu_flags_pkg::IO_PRIVILEGE_LEVEL_LO +: 2];
  assign sel_setup = decode_addr(paddr);
  assign sel_acc = decode_addr(paddr);

  always_comb begin
    st_d = st_q;
    st_d.ev = '0;
    load_mask = 32'h0000_0000;

    // instruction boundary work uses the flags as they stood
    if (retire.valid) begin
      if (retire.redirect) begin
        st_d.ip = retire.target;
      end else begin
        st_d.ip = st_q.ip + {28'h000_0000, retire.len};
      end
      if (st_q.step_armed && st_q.flags[cpu_flags_pkg::TF_BIT]) begin
        st_d.ev.step_trap = 1'b1;
        st_d.flags[cpu_flags_pkg::TF_BIT] = 1'b0;
      end
      // level pin: the core must drop the request once serviced
      st_d.ev.irq_ack = irq_level
                        && st_q.flags[cpu_flags_pkg::IF_BIT];
      // resume covers exactly one instruction
      st_d.flags[cpu_flags_pkg::RF_BIT] = 1'b0;
    end

    if (checks.debug_hit) begin
      st_d.ev.debug_suppress = st_q.flags[cpu_flags_pkg::RF_BIT];
      st_d.ev.debug_fault = !st_q.flags[cpu_flags_pkg::RF_BIT];
    end
    // larger level number means less privilege
    st_d.ev.io_gp = checks.io_req && st_q.pe
                    && (st_q.current_priv_level > io_privilege_level_q);
    st_d.ev.vm_gp = checks.priv_op && st_q.pe
                    && st_q.flags[cpu_flags_pkg::VM_BIT];
    st_d.ev.align_fault = checks.mem_req && checks.misaligned
                          && st_q.am
                          && st_q.flags[cpu_flags_pkg::AC_BIT];

    // arithmetic result flags
    if (alu_req.valid) begin
      st_d.result = calc.result;
      st_d.flags[cpu_flags_pkg::CF_BIT] = calc.cf;
      st_d.flags[cpu_flags_pkg::PF_BIT] = calc.pf;
      st_d.flags[cpu_flags_pkg::AF_BIT] = calc.af;
      st_d.flags[cpu_flags_pkg::ZF_BIT] = calc.zf;
      st_d.flags[cpu_flags_pkg::SF_BIT] = calc.sf;
      st_d.flags[cpu_flags_pkg::OF_BIT] = calc.of;
    end

    // loads of a whole flags value; a load wins over the trap clear
    if (flag_load.valid) begin
      case (flag_load.kind)
        cpu_flags_pkg::LD_TASK: begin
          load_mask = cpu_flags_pkg::FLAGS_DEFINED;
        end
        default: begin
          load_mask = cpu_flags_pkg::POP_MASK;
          if (flag_load.kind == cpu_flags_pkg::LD_IRET) begin
            st_d.ev.task_return =
              st_q.flags[cpu_flags_pkg::NT_BIT];
            if (st_q.current_priv_level == 2'd0) begin
              load_mask[cpu_flags_pkg::VM_BIT] = 1'b1;
            end
          end
          if (st_q.current_priv_level <= io_privilege_level_q) begin
            load_mask[cpu_flags_pkg::IF_BIT] = 1'b1;
          end
        end
      endcase
      load_mask[cpu_flags_pkg::ID_BIT] = st_q.fqe;
      if (!flag_load.wide) begin
        load_mask = load_mask & cpu_flags_pkg::LEGACY_MASK;
      end
      st_d.flags = merge_flags(st_d.flags, flag_load.value, load_mask);
    end

    // apb slave: one wait-free access phase after each setup
    case (st_q.ph)
      cpu_flags_pkg::PH_IDLE: begin
        if (psel && !penable) begin
          st_d.ph = cpu_flags_pkg::PH_ACC;
          st_d.pready = 1'b1;
          st_d.pslverr = !sel_setup[2];
          case (sel_setup[1:0])
            2'd0: st_d.prdata = st_q.flags;
            2'd1: st_d.prdata = st_q.ip;
            2'd2: st_d.prdata = {26'h000_0000, st_q.current_priv_level, 1'b0, st_q.fqe,
                                 st_q.am, st_q.pe};
            default: st_d.prdata = {30'h0000_0000, st_q.step_armed,
                                    irq_level};
          endcase
          if (!sel_setup[2]) begin
            st_d.prdata = 32'h0000_0000;
          end
        end
      end
      default: begin
        if (psel && penable && st_q.pready) begin
          st_d.ph = cpu_flags_pkg::PH_IDLE;
          st_d.pready = 1'b0;
          st_d.pslverr = 1'b0;
          if (pwrite && sel_acc[2]) begin
            case (sel_acc[1:0])
              2'd0: begin
                load_mask = cpu_flags_pkg::FLAGS_DEFINED;
                // only loads and task switches enter legacy mode
                load_mask[cpu_flags_pkg::VM_BIT] = 1'b0;
                load_mask[cpu_flags_pkg::ID_BIT] = st_q.fqe;
                st_d.flags = merge_flags(st_d.flags, pwdata, load_mask);
              end
              2'd1: st_d.ip = pwdata;
              2'd2: begin
                st_d.pe = pwdata[cpu_flags_pkg::CTRL_PE];
                st_d.am = pwdata[cpu_flags_pkg::CTRL_AM];
                st_d.fqe = pwdata[cpu_flags_pkg::CTRL_FQE];
                st_d.current_priv_level = pwdata[cpu_flags_pkg::CTRL_CPL_LO +: 2];
              end
              default: begin
              end
            endcase
          end
        end
      end
    endcase

    // trap arms on the boundary after trap flag is seen set
    if (retire.valid) begin
      st_d.step_armed = st_d.flags[cpu_flags_pkg::TF_BIT];
    end
    st_d.dir_down = st_d.flags[cpu_flags_pkg::DF_BIT];
    st_d.seg_real = !st_d.pe
                    || st_d.flags[cpu_flags_pkg::VM_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.ip <= cpu_flags_pkg::IP_RESET;
      st_q.flags <= cpu_flags_pkg::FLAGS_RESET;
      st_q.current_priv_level <= cpu_flags_pkg::CPL_RESET;
      st_q.ph <= cpu_flags_pkg::PH_IDLE;
      // protection is off out of reset, so segments load real-style
      st_q.seg_real <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign next_instr_pointer = st_q.ip;
  assign status_control_word = st_q.flags;
  assign legacy_flags = st_q.flags[15:0];
  assign alu_result = st_q.result;
  assign dir_down = st_q.dir_down;
  assign seg_real_style = st_q.seg_real;
  assign events = st_q.ev;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ip_step_a: assert property (
    retire.valid && !retire.redirect && !(psel && penable && pwrite)
    |=> next_instr_pointer == $past(st_q.ip) + 32'($past(retire.len)))
    else $error("pointer did not advance by instruction length");

  ip_jump_a: assert property (
    retire.valid && retire.redirect && !(psel && penable && pwrite)
    |=> next_instr_pointer == $past(retire.target))
    else $error("pointer did not take redirect target");

  parity_flag_a: assert property (
    alu_req.valid && !flag_load.valid && !(psel && penable)
    |=> status_control_word[2] == ~^alu_result[7:0])
    else $error("parity flag disagrees with result");

  zero_flag_a: assert property (
    alu_req.valid && !flag_load.valid && !(psel && penable)
    |=> status_control_word[6] == (alu_result == 32'h0000_0000))
    else $error("zero flag disagrees with result");

  carry_add_a: assert property (
    alu_req.valid && !alu_req.sub && alu_req.width == cpu_flags_pkg::W32
    && !flag_load.valid && !(psel && penable)
    |=> status_control_word[0] == (alu_result < $past(alu_req.a)))
    else $error("carry flag wrong for 32-bit add");

  trap_once_a: assert property (
    events.step_trap && !$past(flag_load.valid) && !$past(penable)
    |-> !status_control_word[8] ##1 !events.step_trap)
    else $error("trap flag not cleared by single step");

  irq_gate_a: assert property (
    events.irq_ack |-> $past(status_control_word[9]) && $past(retire.valid))
    else $error("interrupt acknowledged while disabled");

  pop_if_a: assert property (
    flag_load.valid && flag_load.kind != cpu_flags_pkg::LD_TASK
    && st_q.current_priv_level > io_privilege_level_q && !(psel && penable)
    |=> $stable(status_control_word[9]))
    else $error("interrupt flag changed by unprivileged pop");

  vm_entry_a: assert property (
    $rose(status_control_word[17])
    |-> $past(flag_load.valid) && ($past(flag_load.kind)
        == cpu_flags_pkg::LD_TASK || ($past(flag_load.kind)
        == cpu_flags_pkg::LD_IRET && $past(st_q.current_priv_level) == 2'd0)))
    else $error("legacy mode entered by illegal path");

  align_mask_a: assert property (
    !st_q.am |=> !events.align_fault)
    else $error("alignment fault while mask clear");

  bit_one_a: assert property (
    (status_control_word & ~cpu_flags_pkg::FLAGS_DEFINED)
    == cpu_flags_pkg::FLAGS_ONES)
    else $error("reserved flag bits not at fixed value");

  step_taken_c: cover property (events.step_trap);
  irq_taken_c: cover property (events.irq_ack ##1 retire.valid);
  align_seen_c: cover property (events.align_fault);
  apb_write_c: cover property (psel && penable && pwrite && pready);

endmodule : instr_pointer_and_flags_reg

`default_nettype wire

/* tb/tb_top.sv */
/*
  self-checking bench for instr_pointer_and_flags_reg: apb and core strobe
  tasks, one task per scenario, a watchdog and one closing task.
  assumes cpu_flags_pkg is compiled first; assertions sit in the design.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic dir_down, seg_real_style, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ip, flags, alu_result, rq;
  logic [15:0] legacy_flags;
  cpu_flags_pkg::alu_req_s alu_req;
  cpu_flags_pkg::retire_s retire;
  cpu_flags_pkg::flag_load_s flag_load;
  cpu_flags_pkg::checks_s checks;
  cpu_flags_pkg::events_s ev;
  int mismatches, checks_done;

  instr_pointer_and_flags_reg uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alu_req(alu_req),
    .retire(retire), .flag_load(flag_load), .checks(checks),
    .maskable_irq_pin(irq), .next_instr_pointer(ip),
    .status_control_word(flags), .legacy_flags(legacy_flags),
    .alu_result(alu_result), .dir_down(dir_down),
    .seg_real_style(seg_real_style), .events(ev)
  );

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen high; data taken at that edge only
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count is assumed; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic wf(input logic [31:0] d);
    apb(1'b1, cpu_flags_pkg::OFS_FLAGS, d);
  endtask : wf

  task automatic wc(input logic [31:0] d);
    apb(1'b1, cpu_flags_pkg::OFS_CTRL, d);
  endtask : wc

  // strobes pulse for one edge; results are read just after that edge
  task automatic core(input cpu_flags_pkg::retire_s r,
                      input cpu_flags_pkg::flag_load_s f,
                      input logic [4:0] c);
    @(posedge pclk);
    retire <= r;
    flag_load <= f;
    checks <= c;
    @(posedge pclk);
    retire <= '0;
    flag_load <= '0;
    checks <= '0;
    #1;
  endtask : core

  function automatic cpu_flags_pkg::retire_s rt(input logic [3:0] n);
    return '{1'b1, n, 1'b0, 32'h0000_0000};
  endfunction : rt

  function automatic cpu_flags_pkg::flag_load_s ld(
      input cpu_flags_pkg::load_e k, input logic [31:0] v);
    return '{1'b1, k, 1'b1, v};
  endfunction : ld

  task automatic ce(input logic [7:0] e);
    chk({24'h0000_00, ev}, {24'h0000_00, e});
  endtask : ce

  // reference flags built bitwise so no design function is reused
  task automatic alu(input logic s, input cpu_flags_pkg::width_e w,
                     input logic [31:0] a, input logic [31:0] b);
    logic [32:0] m, x, y, r, t;
    logic [31:0] e;
    int n;
    n = (w == cpu_flags_pkg::W8) ? 8 : (w == cpu_flags_pkg::W16) ? 16 : 32;
    m = (33'h1_0000_0000 >> (32 - n)) - 33'h0_0000_0001;
    x = {1'b0, a} & m;
    y = {1'b0, b} & m;
    r = s ? x - y : x + y;
    t = x ^ y ^ r;
    e = 32'h0000_0000;
    e[0] = t[n];
    e[2] = ~^r[7:0];
    e[4] = t[4];
    e[6] = ((r & m) == 33'h0_0000_0000);
    e[7] = r[n-1];
    e[11] = t[n] ^ t[n-1];
    @(posedge pclk);
    alu_req <= '{1'b1, s, w, a, b};
    @(posedge pclk);
    alu_req <= '0;
    #1;
    chk(flags & 32'h0000_08d5, e);
    chk(alu_result, r[31:0] & m[31:0]);
  endtask : alu

  task automatic t_reset;
    chk(flags, cpu_flags_pkg::FLAGS_RESET);
    chk(ip, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({re, rq[30:0]}, 32'h8000_0000);
    wf(32'hffff_ffff);
    chk(flags, 32'h0005_7fd7);
    chk({16'h0000, legacy_flags}, 32'h0000_7fd7);
    chk({31'h0000_0000, dir_down}, 32'h0000_0001);
    wc(32'h0000_0004);
    wf(32'h0020_0000);
    apb(1'b0, cpu_flags_pkg::OFS_FLAGS, 32'h0000_0000);
    chk(rq, 32'h0020_0002);
    chk({31'h0000_0000, dir_down}, 32'h0000_0000);
    wf(32'h0000_0000);
    chk(flags, 32'h0000_0002);
  endtask : t_reset

  task automatic t_ptr;
    core(rt(4'h3), '0, 5'h00);
    chk(ip, 32'h0000_0003);
    core(rt(4'hf), '0, 5'h00);
    chk(ip, 32'h0000_0012);
    core('{1'b1, 4'h2, 1'b1, 32'h0000_1234}, '0, 5'h00);
    chk(ip, 32'h0000_1234);
    apb(1'b1, cpu_flags_pkg::OFS_IP, 32'h0000_0100);
    chk(ip, 32'h0000_0100);
    apb(1'b0, cpu_flags_pkg::OFS_IP, 32'h0000_0000);
    chk(rq, 32'h0000_0100);
  endtask : t_ptr

  task automatic t_alu;
    cpu_flags_pkg::width_e ws[3];
    ws = '{cpu_flags_pkg::W8, cpu_flags_pkg::W16, cpu_flags_pkg::W32};
    foreach (ws[i]) begin
      alu(1'b0, ws[i], 32'hffff_ffff, 32'h0000_0001);
      alu(1'b0, ws[i], 32'h7fff_7f7f, 32'h0000_0001);
      alu(1'b0, ws[i], 32'h7fff_ffff, 32'h0000_0001);
      alu(1'b1, ws[i], 32'h0000_0000, 32'h0000_0001);
      alu(1'b1, ws[i], 32'h8000_8080, 32'h0000_0001);
      alu(1'b0, ws[i], 32'h1234_5678, 32'h0000_0003);
    end
  endtask : t_alu

  task automatic t_trap;
    wf(32'h0000_0100);
    core(rt(4'h1), '0, 5'h00);
    ce(8'h00);
    apb(1'b0, cpu_flags_pkg::OFS_STAT, 32'h0000_0000);
    chk(rq, 32'h0000_0002);
    core(rt(4'h1), '0, 5'h00);
    ce(8'h80);
    chk(flags, 32'h0000_0002);
  endtask : t_trap

  task automatic t_irq;
    @(posedge pclk);
    irq <= 1'b1;
    core(rt(4'h1), '0, 5'h00);
    core(rt(4'h1), '0, 5'h00);
    ce(8'h00);
    wf(32'h0000_0200);
    apb(1'b0, cpu_flags_pkg::OFS_STAT, 32'h0000_0000);
    chk(rq, 32'h0000_0001);
    core(rt(4'h1), '0, 5'h00);
    ce(8'h40);
    @(posedge pclk);
    irq <= 1'b0;
  endtask : t_irq

  task automatic t_priv;
    wc(32'h0000_0031);
    wf(32'h0000_2000);
    core('0, ld(cpu_flags_pkg::LD_POP, 32'h0000_2200), 5'h00);
    chk(flags, 32'h0000_2002);
    core('0, '0, 5'h10);
    ce(8'h20);
    wc(32'h0000_0021);
    core('0, ld(cpu_flags_pkg::LD_POP, 32'h0000_2200), 5'h00);
    chk(flags, 32'h0000_2202);
    core('0, '0, 5'h10);
    ce(8'h00);
  endtask : t_priv

  task automatic t_misc;
    wc(32'h0000_0002);
    apb(1'b0, cpu_flags_pkg::OFS_CTRL, 32'h0000_0000);
    chk(rq, 32'h0000_0002);
    wf(32'h0004_0000);
    core('0, '0, 5'h06);
    ce(8'h08);
    wc(32'h0000_0000);
    core('0, '0, 5'h06);
    ce(8'h00);
    wf(32'h0001_0000);
    core(rt(4'h1), '0, 5'h01);
    ce(8'h02);
    core('0, '0, 5'h01);
    ce(8'h04);
  endtask : t_misc

  // run just before t_rst2: a pop never sets the legacy mode bit; iret at level 0 and task loads do
  task automatic t_vm;
    wc(32'h0000_0001);
    wf(32'h0000_4000);
    core('0, ld(cpu_flags_pkg::LD_POP, 32'h0002_4000), 5'h00);
    chk(flags & 32'h0002_0000, 32'h0000_0000);
    core('0, ld(cpu_flags_pkg::LD_IRET, 32'h0002_0002), 5'h00);
    ce(8'h01);
    chk({flags[17], 30'h0000_0000, seg_real_style}, 32'h8000_0001);
    core('0, '0, 5'h08);
    ce(8'h10);
    wc(32'h0000_0031);
    core('0, ld(cpu_flags_pkg::LD_TASK, 32'h0000_0002), 5'h00);
    chk({flags[17], 30'h0000_0000, seg_real_style}, 32'h0000_0000);
    core('0, ld(cpu_flags_pkg::LD_IRET, 32'h0002_0002), 5'h00);
    chk(flags & 32'h0002_0000, 32'h0000_0000);
    core('0, ld(cpu_flags_pkg::LD_TASK, 32'h0002_0002), 5'h00);
    chk(flags & 32'h0002_0000, 32'h0002_0000);
    // a narrow pop touches only the low half; legacy mode stays set
    core('0, '{1'b1, cpu_flags_pkg::LD_POP, 1'b0, 32'hffff_ffff}, 5'h00);
    chk(flags, 32'h0002_7dd7);
  endtask : t_vm

  // reset in mid-run: state returns to its reset values at once
  task automatic t_rst2;
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk(flags, cpu_flags_pkg::FLAGS_RESET);
    chk(ip, cpu_flags_pkg::IP_RESET);
    chk({31'h0000_0000, seg_real_style}, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cpu_flags_pkg::OFS_FLAGS, 32'h0000_0000);
    chk(rq, cpu_flags_pkg::FLAGS_RESET);
    chk({31'h0000_0000, seg_real_style}, 32'h0000_0001);
  endtask : t_rst2

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // about 160 cycles expected; a hang is cut off well after that
  initial begin
    #200_000;
    mismatches++;
    end_sim;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    irq = 1'b0;
    alu_req = '0;
    retire = '0;
    flag_load = '0;
    checks = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_ptr;
    t_alu;
    t_trap;
    t_irq;
    t_priv;
    t_misc;
    t_vm;
    t_rst2;
    end_sim;
  end
endmodule : tb_top

`default_nettype wire
